// [rtl/cc_unit_pkg.sv]
// constants and carrier types for the compare/capture unit
package cc_unit_pkg;

    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets on the apb slave
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CC_ENABLE = 8'h04;
    localparam logic [7:0] OFS_IRQ_REQUEST = 8'h08;
    localparam logic [7:0] OFS_PORT_LATCH = 8'h0C;
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h10;
    localparam logic [7:0] OFS_CC_REG_BASE = 8'h20;
    localparam logic [7:0] OFS_CC_REG_LAST = 8'h2C;

    // timer_control_reg fields
    localparam int POS_EDGE_SELECT = 0;
    localparam int POS_MODE_SELECT = 1;

    // compare_capture_enable_reg: two bits per channel
    localparam int ENABLE_FIELD_W = 2;

    localparam logic [3:0] RST_PORT_LATCH = 4'hF;
    localparam logic [15:0] RST_CC_REG = 16'h0000;
    localparam logic [7:0] RST_CC_ENABLE = 8'h00;
    localparam logic RST_EDGE_SELECT = 1'b0;
    localparam logic RST_MODE_SELECT = 1'b0;

    typedef enum logic [1:0]
    {
        CH_OFF = 2'b00,
        CH_CAPTURE = 2'b01,
        CH_COMPARE = 2'b10,
        CH_RESERVED = 2'b11
    } ch_mode_type;

    typedef struct packed
    {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

    typedef struct packed
    {
        logic [NUM_CH-1:0][CNT_W-1:0] cc_reg;
        logic [NUM_CH-1:0] latch_a;
        logic [NUM_CH-1:0] latch_b;
        logic [NUM_CH-1:0] det_prev;
        logic [NUM_CH-1:0] req_flag;
        logic [NUM_CH-1:0] sync1;
        logic [NUM_CH-1:0] sync2;
        logic edge_select_bit;
        logic compare_mode_select;
        logic [7:0] enable;
        logic [DATA_W-1:0] prdata;
    } state_type;

endpackage : cc_unit_pkg

// [rtl/cc_unit.sv]
// compare/capture unit with four channels tied to port pin bits 0..3, apb register access
//
// Local design decisions: the register offsets and the APB slave port.
module cc_unit
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [15:0] TIMER_COUNT_IN,
    input wire logic TIMER_OVF_IN,
    input wire logic [3:0] PORT_PIN_IN,
    output logic [3:0] PORT_PIN_OUT,
    output logic [3:0] PORT_PIN_OE_OUT,
    output logic [3:0] REQ_FLAG_OUT
);

    cc_unit_pkg::state_type st_r;
    cc_unit_pkg::state_type st_nxt;
    cc_unit_pkg::apb_req_type req;

    logic [3:0] cmp_on;
    logic [3:0] cap_on;
    logic [3:0] mode1_on;
    logic [3:0] match;
    logic [3:0] det_in;
    logic [3:0] hit;
    logic [3:0] pin_drv;
    logic wr_acc;
    logic rd_setup;

    function automatic cc_unit_pkg::ch_mode_type chan_mode(input logic [7:0] en, input int ch);
        logic [1:0] f;
        f = en[ch*cc_unit_pkg::ENABLE_FIELD_W +: cc_unit_pkg::ENABLE_FIELD_W];
        return cc_unit_pkg::ch_mode_type'(f);
    endfunction : chan_mode

    function automatic logic active_edge(input int ch, input logic prev, input logic cur, input logic sel);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        if (ch == 0)
        begin
            return sel ? rise : fall;
        end
        return rise;
    endfunction : active_edge

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == cc_unit_pkg::OFS_TIMER_CONTROL) || (a == cc_unit_pkg::OFS_CC_ENABLE)
            || (a == cc_unit_pkg::OFS_IRQ_REQUEST) || (a == cc_unit_pkg::OFS_PORT_LATCH)
            || (a == cc_unit_pkg::OFS_PIN_LEVEL)
            || ((a >= cc_unit_pkg::OFS_CC_REG_BASE) && (a <= cc_unit_pkg::OFS_CC_REG_LAST)
                && (a[1:0] == 2'h0));
    endfunction : addr_mapped

    assign req.paddr = PADDR_IN;
    assign req.psel = PSEL_IN;
    assign req.penable = PENABLE_IN;
    assign req.pwrite = PWRITE_IN;
    assign req.pwdata = PWDATA_IN;

    // read data is latched in the setup cycle so the slave can answer with no wait state
    assign wr_acc = req.psel & req.penable & req.pwrite & addr_mapped(req.paddr);
    assign rd_setup = req.psel & ~req.penable & ~req.pwrite;

    always_comb
    begin
        for (int i = 0; i < cc_unit_pkg::NUM_CH; i++)
        begin
            cmp_on[i] = (chan_mode(st_r.enable, i) == cc_unit_pkg::CH_COMPARE);
            cap_on[i] = (chan_mode(st_r.enable, i) == cc_unit_pkg::CH_CAPTURE);
            mode1_on[i] = cmp_on[i] & st_r.compare_mode_select;
            // all four comparators work in parallel on the same count
            match[i] = cmp_on[i] && (TIMER_COUNT_IN == st_r.cc_reg[i]);
            // detector source follows the enable, so a switch can itself look like an edge
            det_in[i] = cmp_on[i] ? match[i] : st_r.sync2[i];
            hit[i] = active_edge(i, st_r.det_prev[i], det_in[i], st_r.edge_select_bit);
            pin_drv[i] = mode1_on[i] ? st_r.latch_b[i] : st_r.latch_a[i];
        end
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = PORT_PIN_IN;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.det_prev = det_in;

        if (wr_acc)
        begin
            unique case (req.paddr)
                cc_unit_pkg::OFS_TIMER_CONTROL:
                begin
                    st_nxt.edge_select_bit = req.pwdata[cc_unit_pkg::POS_EDGE_SELECT];
                    st_nxt.compare_mode_select = req.pwdata[cc_unit_pkg::POS_MODE_SELECT];
                end
                cc_unit_pkg::OFS_CC_ENABLE:
                begin
                    st_nxt.enable = req.pwdata[7:0];
                end
                cc_unit_pkg::OFS_IRQ_REQUEST:
                begin
                    st_nxt.req_flag = st_r.req_flag & ~req.pwdata[3:0];
                end
                cc_unit_pkg::OFS_PORT_LATCH:
                begin
                    for (int i = 0; i < cc_unit_pkg::NUM_CH; i++)
                    begin
                        // mode 0 owns the latch; in mode 1 only latch A is written
                        if (!(cmp_on[i] && !st_r.compare_mode_select))
                        begin
                            st_nxt.latch_a[i] = req.pwdata[i];
                        end
                    end
                end
                default:
                begin
                    for (int i = 0; i < cc_unit_pkg::NUM_CH; i++)
                    begin
                        if (req.paddr[5:2] == 4'(i + 8))
                        begin
                            st_nxt.cc_reg[i] = req.pwdata[15:0];
                        end
                    end
                end
            endcase
        end

        for (int i = 0; i < cc_unit_pkg::NUM_CH; i++)
        begin
            // a hardware set wins over a software clear in the same cycle
            if (hit[i])
            begin
                st_nxt.req_flag[i] = 1'b1;
            end
            // capture also wins over a software write of the same register
            if (cap_on[i] && hit[i])
            begin
                st_nxt.cc_reg[i] = TIMER_COUNT_IN;
            end
            if (cmp_on[i] && !st_r.compare_mode_select)
            begin
                if (match[i])
                begin
                    st_nxt.latch_a[i] = 1'b1;
                end
                else if (TIMER_OVF_IN)
                begin
                    st_nxt.latch_a[i] = 1'b0;
                end
            end
            // outside mode 1 latch B shadows latch A, so entering mode 1 leaves the pin still
            if (mode1_on[i])
            begin
                if (match[i])
                begin
                    st_nxt.latch_b[i] = st_r.latch_a[i];
                end
            end
            else
            begin
                st_nxt.latch_b[i] = st_nxt.latch_a[i];
            end
        end

        if (rd_setup)
        begin
            st_nxt.prdata = 32'h0000_0000;
            unique case (req.paddr)
                cc_unit_pkg::OFS_TIMER_CONTROL:
                begin
                    st_nxt.prdata[cc_unit_pkg::POS_EDGE_SELECT] = st_r.edge_select_bit;
                    st_nxt.prdata[cc_unit_pkg::POS_MODE_SELECT] = st_r.compare_mode_select;
                end
                cc_unit_pkg::OFS_CC_ENABLE:
                begin
                    st_nxt.prdata[7:0] = st_r.enable;
                end
                cc_unit_pkg::OFS_IRQ_REQUEST:
                begin
                    st_nxt.prdata[3:0] = st_r.req_flag;
                end
                cc_unit_pkg::OFS_PORT_LATCH:
                begin
                    st_nxt.prdata[3:0] = st_r.latch_a;
                end
                cc_unit_pkg::OFS_PIN_LEVEL:
                begin
                    st_nxt.prdata[3:0] = st_r.sync2;
                end
                default:
                begin
                    for (int i = 0; i < cc_unit_pkg::NUM_CH; i++)
                    begin
                        if (addr_mapped(req.paddr) && req.paddr[5:2] == 4'(i + 8))
                        begin
                            st_nxt.prdata[15:0] = st_r.cc_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            st_r.cc_reg <= {cc_unit_pkg::NUM_CH{cc_unit_pkg::RST_CC_REG}};
            st_r.latch_a <= cc_unit_pkg::RST_PORT_LATCH;
            st_r.latch_b <= cc_unit_pkg::RST_PORT_LATCH;
            st_r.det_prev <= 4'h0;
            st_r.req_flag <= 4'h0;
            st_r.sync1 <= 4'h0;
            st_r.sync2 <= 4'h0;
            st_r.edge_select_bit <= cc_unit_pkg::RST_EDGE_SELECT;
            st_r.compare_mode_select <= cc_unit_pkg::RST_MODE_SELECT;
            st_r.enable <= cc_unit_pkg::RST_CC_ENABLE;
            st_r.prdata <= 32'h0000_0000;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA_OUT = st_r.prdata;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = req.psel & req.penable & ~addr_mapped(req.paddr);
    assign PORT_PIN_OUT = pin_drv;
    // quasi-bidirectional pin: outside compare mode a latched one releases it so an outside source can pull it
    assign PORT_PIN_OE_OUT = cmp_on | ~pin_drv;
    assign REQ_FLAG_OUT = st_r.req_flag;

    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_B_IN);

    a_compare_drives_pin: assert property (cmp_on[0] |-> PORT_PIN_OE_OUT[0] && PORT_PIN_OE_OUT[0] == 1'b1)
        else $error("compare channel 0 pin not driven");

    a_mode0_overflow_clear: assert property (cmp_on[1] && !st_r.compare_mode_select && TIMER_OVF_IN
        && !match[1] && $stable(st_r.enable) ##1 cmp_on[1] && !st_r.compare_mode_select |-> !PORT_PIN_OUT[1])
        else $error("overflow did not clear mode 0 latch");

    a_mode0_match_set: assert property (cmp_on[2] && !st_r.compare_mode_select && match[2]
        ##1 cmp_on[2] && !st_r.compare_mode_select |-> PORT_PIN_OUT[2])
        else $error("match did not set mode 0 latch");

    a_mode0_write_blocked: assert property (cmp_on[3] && !st_r.compare_mode_select && !match[3]
        && !TIMER_OVF_IN |=> st_r.latch_a[3] == $past(st_r.latch_a[3]))
        else $error("mode 0 latch changed without overflow or match");

    a_capture_loads_timer: assert property (cap_on[0] && hit[0] |=> st_r.cc_reg[0] == $past(TIMER_COUNT_IN)
        && st_r.req_flag[0])
        else $error("capture did not load timer and flag");

    a_mode1_hold_pin: assert property (mode1_on[0] && !match[0] ##1 mode1_on[0]
        |-> PORT_PIN_OUT[0] == $past(PORT_PIN_OUT[0]))
        else $error("mode 1 pin moved without match");

    a_mode1_match_copy: assert property (mode1_on[1] && match[1] && !st_r.det_prev[1] ##1 mode1_on[1]
        |-> PORT_PIN_OUT[1] == $past(st_r.latch_a[1]) && st_r.req_flag[1])
        else $error("mode 1 match did not copy latch A and flag");

    a_rising_sets_flag: assert property (!cmp_on[2] && st_r.sync2[2] && !st_r.det_prev[2]
        |=> st_r.req_flag[2])
        else $error("rising pin edge did not set flag");

    a_falling_select: assert property (!cmp_on[0] && !st_r.edge_select_bit && st_r.det_prev[0]
        && !st_r.sync2[0] && !(wr_acc && req.paddr == cc_unit_pkg::OFS_IRQ_REQUEST)
        ##1 !st_r.req_flag[0] |-> 1'b0)
        else $error("falling edge with select zero missed");

    a_pin1_rise_flag: assert property (!cmp_on[1] && st_r.sync2[1] && !st_r.det_prev[1]
        |=> st_r.req_flag[1])
        else $error("rising edge on pin 1 did not set flag");

    a_pin3_fall_quiet: assert property (!cmp_on[3] && !st_r.sync2[3] && st_r.det_prev[3] && !st_r.req_flag[3]
        |=> !st_r.req_flag[3])
        else $error("falling edge on pin 3 set flag");

    a_pin0_rise_select: assert property (!cmp_on[0] && st_r.edge_select_bit && st_r.sync2[0] && !st_r.det_prev[0]
        |=> st_r.req_flag[0])
        else $error("rising edge with select one missed");

    a_pin0_rise_ignored: assert property (!cmp_on[0] && !st_r.edge_select_bit && st_r.sync2[0]
        && !st_r.det_prev[0] && !st_r.req_flag[0] |=> !st_r.req_flag[0])
        else $error("rising edge with select zero set flag");

    a_cmp_edge_rise: assert property (cmp_on[0] && st_r.edge_select_bit && match[0] && !st_r.det_prev[0]
        |=> st_r.req_flag[0])
        else $error("comparator rising edge missed");

    a_cmp_edge_fall: assert property (cmp_on[0] && !st_r.edge_select_bit && !match[0] && st_r.det_prev[0]
        |=> st_r.req_flag[0])
        else $error("comparator falling edge missed");

    a_cmp_pin_ignored: assert property (cmp_on[1] && !match[1] && !st_r.req_flag[1]
        |=> !st_r.req_flag[1])
        else $error("pin reached flag in compare mode");

    a_capture_pin3: assert property (cap_on[3] && hit[3]
        |=> st_r.cc_reg[3] == $past(TIMER_COUNT_IN) && st_r.req_flag[3])
        else $error("capture on channel 3 failed");

    a_capture_hold: assert property (cap_on[2] && !hit[2] && !wr_acc
        |=> st_r.cc_reg[2] == $past(st_r.cc_reg[2]))
        else $error("capture register moved without edge");

    a_off_no_capture: assert property (!cap_on[1] && !wr_acc
        |=> st_r.cc_reg[1] == $past(st_r.cc_reg[1]))
        else $error("register loaded outside capture mode");

    a_compare_pin3_out: assert property (cmp_on[3]
        |-> PORT_PIN_OE_OUT[3])
        else $error("compare channel 3 pin not driven");

    a_split_keep_pin: assert property ($rose(mode1_on[2]) && $stable(st_r.latch_a[2])
        |-> PORT_PIN_OUT[2] == $past(PORT_PIN_OUT[2]))
        else $error("pin moved on entry to mode 1");

    a_mode1_rematch: assert property (mode1_on[3] && match[3] && !st_r.det_prev[3]
        |=> st_r.req_flag[3])
        else $error("mode 1 match did not set flag");

    a_flag_set_wins: assert property (hit[2]
        |=> st_r.req_flag[2])
        else $error("edge lost against flag clear");

    a_flag_clear: assert property (wr_acc && req.paddr == cc_unit_pkg::OFS_IRQ_REQUEST && req.pwdata[1]
        && !hit[1] |=> !st_r.req_flag[1])
        else $error("flag clear had no effect");

    a_rd_enable_data: assert property (rd_setup && req.paddr == cc_unit_pkg::OFS_CC_ENABLE
        |=> PRDATA_OUT[7:0] == $past(st_r.enable))
        else $error("enable register read wrong");

    a_unmapped_err: assert property (PSEL_IN && PENABLE_IN && PADDR_IN == 8'h40
        |-> PSLVERR_OUT)
        else $error("unmapped access without error");

    a_count_match_sets: assert property (cmp_on[3] && !st_r.compare_mode_select
        && TIMER_COUNT_IN == st_r.cc_reg[3] |=> st_r.latch_a[3])
        else $error("equal count did not set mode 0 latch");

    a_ready_high: assert property (PSEL_IN && PENABLE_IN
        |-> PREADY_OUT)
        else $error("access cycle without ready");

endmodule : cc_unit

// [testbench/pin_pullup_model.sv]
// far side of the port pins: pull-ups plus one optional outside driver per pin
module pin_pullup_model
(
    input wire logic [3:0] pin_out_in,
    input wire logic [3:0] pin_oe_in,
    input wire logic [3:0] ext_en_in,
    input wire logic [3:0] ext_val_in,
    output logic [3:0] pin_level_out
);
    // wired-and: the outside source can pull low any pin whose output is one, whether released or driven
    assign pin_level_out = (pin_oe_in ? pin_out_in : 4'hF) & (ext_en_in ? ext_val_in : 4'hF);
endmodule : pin_pullup_model

// [testbench/timer2_compare_capture_unit_test.sv]
// self-checking bench for the compare/capture unit
module timer2_compare_capture_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in;
    logic rst_b_in;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] tcount;
    logic tovf;
    logic [3:0] pin_lvl;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] flags;
    logic [3:0] ext_en;
    logic [3:0] ext_val;
    logic [31:0] rd;
    logic err;
    int miscompares;
    int n_tests;

    cc_unit u_dut
    (
        .MCLK_IN(mclk_in),
        .RST_B_IN(rst_b_in),
        .PADDR_IN(paddr),
        .PSEL_IN(psel),
        .PENABLE_IN(penable),
        .PWRITE_IN(pwrite),
        .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata),
        .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr),
        .TIMER_COUNT_IN(tcount),
        .TIMER_OVF_IN(tovf),
        .PORT_PIN_IN(pin_lvl),
        .PORT_PIN_OUT(pin_out),
        .PORT_PIN_OE_OUT(pin_oe),
        .REQ_FLAG_OUT(flags)
    );

    pin_pullup_model u_pins
    (
        .pin_out_in(pin_out),
        .pin_oe_in(pin_oe),
        .ext_en_in(ext_en),
        .ext_val_in(ext_val),
        .pin_level_out(pin_lvl)
    );

    initial
    begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one apb transfer; waits on pready with a bound so a dead slave cannot hang the run
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge mclk_in);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        if (i >= 16)
        begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // settle the synchronisers, then clear every sticky flag
    task automatic settle_clear();
        repeat (6) @(posedge mclk_in);
        apb(1'b1, cc_unit_pkg::OFS_IRQ_REQUEST, 32'h0000000F);
        @(posedge mclk_in);
    endtask : settle_clear

    // one cycle of timer count equal to v, then back to a count no channel uses
    task automatic hit(input logic [15:0] v);
        @(posedge mclk_in);
        tcount <= v;
        @(posedge mclk_in);
        tcount <= 16'h0001;
        repeat (2) @(posedge mclk_in);
    endtask : hit

    task automatic t_reset();
        apb(1'b0, cc_unit_pkg::OFS_PORT_LATCH, 32'h0);
        chk("latch_rst", rd, 32'h0000000F);
        apb(1'b0, cc_unit_pkg::OFS_CC_REG_BASE, 32'h0);
        chk("cc0_rst", rd, 32'h00000000);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h00000001);
        chk("oe_rst", {28'h0, pin_oe}, 32'h00000000);
        settle_clear();
        chk("flags_clr", {28'h0, flags}, 32'h00000000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_edges();
        ext_en[1] <= 1'b1;
        ext_val[1] <= 1'b1;
        settle_clear();
        ext_val[1] <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk("fall_pin1", {31'h0, flags[1]}, 32'h0);
        ext_val[1] <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk("rise_pin1", {31'h0, flags[1]}, 32'h1);
        ext_en[1] <= 1'b0;
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'h7);
        settle_clear();
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'hF);
        repeat (6) @(posedge mclk_in);
        chk("toggle_pin3", {31'h0, flags[3]}, 32'h1);
        $display("test edges done");
    endtask : t_edges

    task automatic t_capture();
        apb(1'b1, cc_unit_pkg::OFS_TIMER_CONTROL, 32'h1);
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h1);
        ext_en[0] <= 1'b1;
        ext_val[0] <= 1'b1;
        tcount <= 16'h1234;
        settle_clear();
        ext_val[0] <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk("fall_cap0", {31'h0, flags[0]}, 32'h0);
        ext_val[0] <= 1'b1;
        repeat (6) @(posedge mclk_in);
        chk("rise_cap0", {31'h0, flags[0]}, 32'h1);
        apb(1'b0, cc_unit_pkg::OFS_CC_REG_BASE, 32'h0);
        chk("cap_value", rd, 32'h00001234);
        tcount <= 16'h0001;
        ext_en[0] <= 1'b0;
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h0);
        $display("test capture done");
    endtask : t_capture

    task automatic t_mode0();
        apb(1'b1, cc_unit_pkg::OFS_TIMER_CONTROL, 32'h0);
        apb(1'b1, 8'h24, 32'h0050);
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h08);
        settle_clear();
        chk("oe_cmp1", {31'h0, pin_oe[1]}, 32'h1);
        @(posedge mclk_in);
        tovf <= 1'b1;
        @(posedge mclk_in);
        tovf <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("ovf_clr1", {31'h0, pin_out[1]}, 32'h0);
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'hF);
        repeat (2) @(posedge mclk_in);
        chk("sw_locked1", {31'h0, pin_out[1]}, 32'h0);
        hit(16'h0050);
        chk("match_set1", {31'h0, pin_out[1]}, 32'h1);
        chk("match_flag1", {31'h0, flags[1]}, 32'h1);
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h0);
        $display("test mode0 done");
    endtask : t_mode0

    task automatic t_mode1();
        apb(1'b1, cc_unit_pkg::OFS_TIMER_CONTROL, 32'h2);
        apb(1'b1, 8'h28, 32'h0100);
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'hF);
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h20);
        repeat (2) @(posedge mclk_in);
        chk("split_keep2", {31'h0, pin_out[2]}, 32'h1);
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'hB);
        settle_clear();
        chk("latch_b_hold2", {31'h0, pin_out[2]}, 32'h1);
        hit(16'h0100);
        chk("copy_a2", {31'h0, pin_out[2]}, 32'h0);
        chk("flag_a2", {31'h0, flags[2]}, 32'h1);
        apb(1'b1, cc_unit_pkg::OFS_IRQ_REQUEST, 32'hF);
        hit(16'h0100);
        chk("again_flag2", {31'h0, flags[2]}, 32'h1);
        chk("again_pin2", {31'h0, pin_out[2]}, 32'h0);
        $display("test mode1 done");
    endtask : t_mode1

    task automatic t_soft_cap();
        apb(1'b1, cc_unit_pkg::OFS_TIMER_CONTROL, 32'h0);
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h40);
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'h7);
        apb(1'b1, cc_unit_pkg::OFS_CC_REG_BASE, 32'h0);
        tcount <= 16'h0ABC;
        settle_clear();
        apb(1'b1, cc_unit_pkg::OFS_PORT_LATCH, 32'hF);
        repeat (6) @(posedge mclk_in);
        chk("soft_flag3", {31'h0, flags[3]}, 32'h1);
        apb(1'b0, cc_unit_pkg::OFS_CC_REG_LAST, 32'h0);
        chk("soft_cap3", rd, 32'h00000ABC);
        settle_clear();
        apb(1'b1, cc_unit_pkg::OFS_CC_ENABLE, 32'h42);
        repeat (2) @(posedge mclk_in);
        chk("switch_flag0", {31'h0, flags[0]}, 32'h1);
        $display("test soft capture done");
    endtask : t_soft_cap

    initial
    begin
        miscompares = 0;
        n_tests = 0;
        rst_b_in = 1'b0;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        tcount = 16'h0001;
        tovf = 1'b0;
        ext_en = 4'h0;
        ext_val = 4'hF;
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_edges();
        t_capture();
        t_mode0();
        t_mode1();
        t_soft_cap();
        close_out();
    end
endmodule : timer2_compare_capture_unit_test
